// ==== logic/gfx_map_compare_mask.sv ====
// Graphics map select, colour-ignore and bit-mask registers with the
// host aperture decode and plane access sequencer.
// Assumes the index register, mode and compare registers and the plane
// memory sit outside on the same clock; plane reads return one cycle later.
`default_nettype none
module gfx_map_compare_mask (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Indexed register port
  input  wire logic [7:0]  reg_index,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Controls from neighbouring registers
  input  wire logic        pci_mem_enable,
  input  wire logic [7:0]  misc_output_control,
  input  wire logic        read_mode_1,
  input  wire logic [3:0]  compare_colour,
  input  wire logic [1:0]  read_plane_sel,
  input  wire logic [3:0]  plane_write_enable,
  // Mode outputs
  output logic             graphics_mode,
  output logic             odd_even_chain,
  // Host memory cycle
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [19:0] mem_addr,
  input  wire logic [31:0] write_path_data,
  output logic             mem_claim,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata,
  // Plane memory
  output logic      [15:0] plane_addr,
  output logic             plane_rd,
  output logic      [3:0]  plane_we,
  output logic      [31:0] plane_wdata,
  input  wire logic [31:0] plane_rdata
);

  typedef struct packed {
    gfx_map_pkg::state_type st;
    logic [3:0]             misc;
    logic [3:0]             ignore;
    logic [7:0]             mask;
    logic [7:0]             reg_rdata;
    logic [31:0]            latch;
    logic [1:0]             rsel;
    logic [15:0]            plane_addr;
    logic                   plane_rd;
    logic [3:0]             plane_we;
    logic [31:0]            plane_wdata;
    logic                   mem_ack;
    logic [7:0]             mem_rdata;
  } regs_type;

  regs_type s_r;
  regs_type s_nxt;

  plane_dp_if dpi ();

  logic [1:0]  map_sel;
  logic        chain;
  logic        in_window;
  logic        enabled;
  logic [15:0] offset;
  logic [3:0]  pair_mask;

  assign map_sel = s_r.misc[gfx_map_pkg::MAP_LSB +: 2];
  assign chain   = s_r.misc[gfx_map_pkg::CHAIN_BIT];

  // Aperture window decode
  always_comb begin
    if (map_sel == gfx_map_pkg::MAP_128K) begin
      in_window = (mem_addr >= gfx_map_pkg::APER_A_LO) &&
                  (mem_addr <= gfx_map_pkg::APER_B_HI);
    end else if (map_sel == gfx_map_pkg::MAP_A64K) begin
      in_window = (mem_addr >= gfx_map_pkg::APER_A_LO) &&
                  (mem_addr <= gfx_map_pkg::APER_A_HI);
    end else if (map_sel == gfx_map_pkg::MAP_B32K) begin
      in_window = (mem_addr >= gfx_map_pkg::APER_B_LO) &&
                  (mem_addr <= gfx_map_pkg::APER_B_MID);
    end else begin
      in_window = (mem_addr >= gfx_map_pkg::APER_B8_LO) &&
                  (mem_addr <= gfx_map_pkg::APER_B_HI);
    end
  end

  assign enabled = pci_mem_enable &&
                   misc_output_control[gfx_map_pkg::MEM_EN_BIT];
  // One cycle at a time; out-of-window cycles are left for other targets
  assign mem_claim = mem_req && enabled && in_window &&
                     (s_r.st == gfx_map_pkg::ST_IDLE);

  // Chained mode folds A0 out of the plane offset
  assign offset    = chain ? {1'b0, mem_addr[15:1]} : mem_addr[15:0];
  assign pair_mask = !chain ? 4'b1111 : (mem_addr[0] ? 4'b1010 : 4'b0101);

  // Datapath operands
  assign dpi.latch      = s_r.latch;
  assign dpi.wpath      = write_path_data;
  assign dpi.planes     = plane_rdata;
  assign dpi.mask       = s_r.mask;
  assign dpi.cmp_en     = s_r.ignore;
  assign dpi.cmp_colour = compare_colour;
  assign dpi.rmode1     = read_mode_1;
  assign dpi.rsel       = s_r.rsel;

  plane_datapath u_dp (
    .dp (dpi.dp)
  );

  always_comb begin
    s_nxt          = s_r;
    s_nxt.mem_ack  = 1'b0;
    s_nxt.plane_rd = 1'b0;
    s_nxt.plane_we = 4'h0;

    // Register port; reserved nibbles are dropped on write
    if (reg_wr) begin
      if (reg_index == gfx_map_pkg::IDX_MISC) begin
        s_nxt.misc = reg_wdata[3:0];
      end else if (reg_index == gfx_map_pkg::IDX_IGNORE) begin
        s_nxt.ignore = reg_wdata[3:0];
      end else if (reg_index == gfx_map_pkg::IDX_MASK) begin
        s_nxt.mask = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_index == gfx_map_pkg::IDX_MISC) begin
        s_nxt.reg_rdata = {4'h0, s_r.misc};
      end else if (reg_index == gfx_map_pkg::IDX_IGNORE) begin
        s_nxt.reg_rdata = {4'h0, s_r.ignore};
      end else if (reg_index == gfx_map_pkg::IDX_MASK) begin
        s_nxt.reg_rdata = s_r.mask;
      end else begin
        s_nxt.reg_rdata = 8'h00;
      end
    end

    case (s_r.st)
      gfx_map_pkg::ST_IDLE: begin
        if (mem_claim) begin
          s_nxt.plane_addr = offset;
          if (mem_we) begin
            // Mask uses latches as they stand now, so read first
            s_nxt.plane_wdata = dpi.wr_data;
            s_nxt.plane_we    = plane_write_enable & pair_mask;
            s_nxt.mem_ack     = 1'b1;
          end else begin
            s_nxt.rsel     = chain ? {read_plane_sel[1], mem_addr[0]}
                                   : read_plane_sel;
            s_nxt.plane_rd = 1'b1;
            s_nxt.st       = gfx_map_pkg::ST_RD_REQ;
          end
        end
      end
      gfx_map_pkg::ST_RD_REQ: begin
        s_nxt.st = gfx_map_pkg::ST_RD_DATA;
      end
      gfx_map_pkg::ST_RD_DATA: begin
        s_nxt.latch     = plane_rdata;
        s_nxt.mem_rdata = dpi.rd_data;
        s_nxt.mem_ack   = 1'b1;
        s_nxt.st        = gfx_map_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.st = gfx_map_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r        <= '0;
      s_r.st     <= gfx_map_pkg::ST_IDLE;
      s_r.misc   <= gfx_map_pkg::MISC_RST;
      s_r.ignore <= gfx_map_pkg::IGNORE_RST;
      s_r.mask   <= gfx_map_pkg::MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata      = s_r.reg_rdata;
  assign graphics_mode  = s_r.misc[gfx_map_pkg::GFX_BIT];
  assign odd_even_chain = chain;
  assign mem_ack        = s_r.mem_ack;
  assign mem_rdata      = s_r.mem_rdata;
  assign plane_addr     = s_r.plane_addr;
  assign plane_rd       = s_r.plane_rd;
  assign plane_we       = s_r.plane_we;
  assign plane_wdata    = s_r.plane_wdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_b_window;
    mem_claim && map_sel == gfx_map_pkg::MAP_B32K |-> mem_addr[19:15] == 5'b1_0110;
  endproperty
  a_b_window: assert property (p_b_window)
    else $error("claim outside B0000-B7FFF window");

  property p_claim_enable;
    mem_claim |-> pci_mem_enable && misc_output_control[1];
  endproperty
  a_claim_enable: assert property (p_claim_enable)
    else $error("claim without memory enables");

  property p_no_claim_out;
    mem_req && map_sel == gfx_map_pkg::MAP_A64K && mem_addr[19:16] != 4'hA |-> !mem_claim;
  endproperty
  a_no_claim_out: assert property (p_no_claim_out)
    else $error("claimed address outside A window");

  property p_chain_even;
    mem_claim && mem_we && chain && !mem_addr[0] |=> plane_we == ($past(plane_write_enable) & 4'b0101);
  endproperty
  a_chain_even: assert property (p_chain_even)
    else $error("even address wrote odd planes");

  property p_misc_high_zero;
    reg_rd && reg_index == 8'h06 |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_misc_high_zero: assert property (p_misc_high_zero)
    else $error("misc upper nibble not zero");

  property p_mask_latch;
    plane_we != 4'h0 |-> ((plane_wdata ^ $past(s_r.latch)) & ~{4{$past(s_r.mask)}}) == 32'h0000_0000;
  endproperty
  a_mask_latch: assert property (p_mask_latch)
    else $error("masked bit not taken from latch");

  property p_latch_load;
    s_r.st == gfx_map_pkg::ST_RD_DATA |=> s_r.latch == $past(plane_rdata) ##0 mem_ack;
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("read latches not loaded");

  property p_all_ignored;
    s_r.st == gfx_map_pkg::ST_RD_DATA && read_mode_1 && s_r.ignore == 4'h0 |=> mem_rdata == 8'hFF;
  endproperty
  a_all_ignored: assert property (p_all_ignored)
    else $error("excluded planes affected compare");

  property p_mismatch;
    s_r.st == gfx_map_pkg::ST_RD_DATA && read_mode_1 && s_r.ignore[0] &&
    plane_rdata[7:0] == ~{8{compare_colour[0]}} |=> mem_rdata == 8'h00;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("mismatch reported as match");

  property p_read_ack;
    mem_claim && !mem_we |-> ##1 plane_rd ##2 mem_ack;
  endproperty
  a_read_ack: assert property (p_read_ack)
    else $error("read sequence timing wrong");

  property p_mode0_select;
    s_r.st == gfx_map_pkg::ST_RD_DATA && !read_mode_1 |=>
      mem_rdata == $past(plane_rdata[{s_r.rsel, 3'b000} +: 8]);
  endproperty
  a_mode0_select: assert property (p_mode0_select)
    else $error("read mode 0 byte not from selected plane");

  property p_unchained_all;
    mem_claim && mem_we && !chain |=> plane_we == $past(plane_write_enable);
  endproperty
  a_unchained_all: assert property (p_unchained_all)
    else $error("write did not reach all enabled planes");

  property p_mask_pass;
    plane_we != 4'h0 |->
      ((plane_wdata ^ $past(write_path_data)) & {4{$past(s_r.mask)}}) == 32'h0000_0000;
  endproperty
  a_mask_pass: assert property (p_mask_pass)
    else $error("unmasked bit not taken from write path");

  // Mode bit must track the last misc write so the attribute side can match it
  property p_gfx_follow;
    reg_wr && reg_index == gfx_map_pkg::IDX_MISC |=>
      graphics_mode == $past(reg_wdata[gfx_map_pkg::GFX_BIT]);
  endproperty
  a_gfx_follow: assert property (p_gfx_follow)
    else $error("graphics mode does not follow misc write");

  property p_ignore_high_zero;
    reg_rd && reg_index == gfx_map_pkg::IDX_IGNORE |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_ignore_high_zero: assert property (p_ignore_high_zero)
    else $error("colour-ignore upper nibble not zero");

  c_read:   cover property (mem_claim && !mem_we ##3 mem_ack);
  c_write:  cover property (mem_claim && mem_we ##1 plane_we != 4'h0);
  c_mode1:  cover property (s_r.st == gfx_map_pkg::ST_RD_DATA && read_mode_1);
  c_chain:  cover property (mem_claim && mem_we && chain);
  c_b8:     cover property (mem_claim && map_sel == gfx_map_pkg::MAP_B8_32K);

endmodule : gfx_map_compare_mask
`default_nettype wire

// ==== logic/gfx_map_pkg.sv ====
// Constants for the graphics map / compare / bit-mask register block.
// Assumes one display-core clock and the indexed I/O data port outside.
`default_nettype none
package gfx_map_pkg;
  // Register indexes on the graphics data port
  localparam logic [7:0] IDX_MISC   = 8'h06;
  localparam logic [7:0] IDX_IGNORE = 8'h07;
  localparam logic [7:0] IDX_MASK   = 8'h08;
  // Field positions in misc_map_select
  localparam int GFX_BIT   = 0;
  localparam int CHAIN_BIT = 1;
  localparam int MAP_LSB   = 2;
  // Field position in misc_output_control
  localparam int MEM_EN_BIT = 1;
  // Reset values (undefined on the real part, zero here)
  localparam logic [3:0] MISC_RST   = 4'h0;
  localparam logic [3:0] IGNORE_RST = 4'h0;
  localparam logic [7:0] MASK_RST   = 8'h00;
  // Map select encodings
  localparam logic [1:0] MAP_128K = 2'b00;
  localparam logic [1:0] MAP_A64K = 2'b01;
  localparam logic [1:0] MAP_B32K = 2'b10;
  localparam logic [1:0] MAP_B8_32K = 2'b11;
  // Aperture limits
  localparam logic [19:0] APER_A_LO  = 20'hA_0000;
  localparam logic [19:0] APER_A_HI  = 20'hA_FFFF;
  localparam logic [19:0] APER_B_LO  = 20'hB_0000;
  localparam logic [19:0] APER_B_MID = 20'hB_7FFF;
  localparam logic [19:0] APER_B8_LO = 20'hB_8000;
  localparam logic [19:0] APER_B_HI  = 20'hB_FFFF;
  // Host memory cycle sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_RD_REQ, ST_RD_DATA} state_type;
endpackage : gfx_map_pkg
`default_nettype wire

// ==== logic/plane_dp_if.sv ====
// Carries plane data between the register core and the plane datapath.
// Assumes both ends sit on the same clock; the datapath is combinational.
`default_nettype none
interface plane_dp_if;
  logic [31:0] latch;
  logic [31:0] wpath;
  logic [31:0] planes;
  logic [31:0] wr_data;
  logic [7:0]  mask;
  logic [7:0]  rd_data;
  logic [3:0]  cmp_en;
  logic [3:0]  cmp_colour;
  logic        rmode1;
  logic [1:0]  rsel;
  modport core (output latch, wpath, planes, mask, cmp_en, cmp_colour, rmode1, rsel,
                input  wr_data, rd_data);
  modport dp   (input  latch, wpath, planes, mask, cmp_en, cmp_colour, rmode1, rsel,
                output wr_data, rd_data);
endinterface : plane_dp_if
`default_nettype wire

// ==== logic/plane_datapath.sv ====
// Combinational plane datapath: write bit mask and read compare/select.
// Assumes the core presents stable operands and registers the results.
`default_nettype none
module plane_datapath (
  plane_dp_if.dp dp
);
  genvar g;
  logic [7:0] match_bit;

  // Mask after rotate, logic op and set/reset, which arrive merged in wpath
  generate
    for (g = 0; g < 4; g++) begin : g_plane
      assign dp.wr_data[g*8 +: 8] = (dp.wpath[g*8 +: 8] & dp.mask) |
                                    (dp.latch[g*8 +: 8] & ~dp.mask);
    end
    for (g = 0; g < 8; g++) begin : g_bit
      // Excluded planes count as matching
      assign match_bit[g] = &(~dp.cmp_en | ~({dp.planes[24+g], dp.planes[16+g],
                                              dp.planes[8+g], dp.planes[g]} ^
                                             dp.cmp_colour));
    end
  endgenerate

  assign dp.rd_data = dp.rmode1 ? match_bit
                                : dp.planes[{dp.rsel, 3'b000} +: 8];
endmodule : plane_datapath
`default_nettype wire

// ==== dv/plane_mem_model.sv ====
// Four-plane frame memory standing on the plane port of the block.
// Assumes one-cycle read latency; data is only valid in the cycle after a read.
`default_nettype none
module plane_mem_model (
  // Clock
  input  wire logic        clk,
  // Plane port
  input  wire logic [15:0] plane_addr,
  input  wire logic        plane_rd,
  input  wire logic [3:0]  plane_we,
  input  wire logic [31:0] plane_wdata,
  output logic      [31:0] plane_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [15:0]];
  logic        valid_r = 1'b0;
  initial plane_rdata = 32'h0000_0000;
  always @(posedge clk) begin
    valid_r <= plane_rd;
    if (plane_rd)
      plane_rdata <= mem.exists(plane_addr) ? mem[plane_addr] : 32'h0000_0000;
    else if (valid_r)
      plane_rdata <= ~plane_rdata;
    for (int p = 0; p < 4; p++) begin
      if (plane_we[p]) begin
        if (!mem.exists(plane_addr))
          mem[plane_addr] = 32'h0000_0000;
        mem[plane_addr][8*p+:8] = plane_wdata[8*p+:8];
      end
    end
  end
endmodule : plane_mem_model
`default_nettype wire

// ==== dv/vga_gfx_map_compare_mask_tb_top.sv ====
// Self-checking bench for the map select, colour-ignore and bit-mask block.
// Assumes the plane memory model on the plane port; the bench acts as host.
`default_nettype none
module vga_gfx_map_compare_mask_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pci_en = 1, rm1 = 0;
  logic        mem_req = 0, mem_we = 0, gfx, chn, claim, ack, prd;
  logic [7:0]  reg_index = 0, reg_wdata = 0, moc = 8'h02, reg_rdata, mem_rdata;
  logic [3:0]  colour = 0, pwe = 4'hF, pwe_o, misc_m = 0, ign_m = 0;
  logic [1:0]  rsel = 0;
  logic [19:0] mem_addr = 0;
  logic [31:0] wpath = 0, pwdata, prdata, latch_m = 0;
  logic [15:0] paddr;
  logic [7:0]  mask_m = 0;
  logic [31:0] mem_m [logic [15:0]];
  logic [19:0] bases [8] = '{20'h9_FFF0, 20'hA_0000, 20'hA_FFF0, 20'hB_0000,
                             20'hB_7FF0, 20'hB_8000, 20'hB_FFF0, 20'hC_0000};
  int          errors = 0, total_checks = 0, seed;
  always #50 clk = ~clk;
  gfx_map_compare_mask gfx_map_compare_mask_i (
    .clk(clk), .rst(rst), .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pci_mem_enable(pci_en),
    .misc_output_control(moc), .read_mode_1(rm1), .compare_colour(colour),
    .read_plane_sel(rsel), .plane_write_enable(pwe), .graphics_mode(gfx),
    .odd_even_chain(chn), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .write_path_data(wpath), .mem_claim(claim), .mem_ack(ack), .mem_rdata(mem_rdata),
    .plane_addr(paddr), .plane_rd(prd), .plane_we(pwe_o), .plane_wdata(pwdata),
    .plane_rdata(prdata));
  plane_mem_model plane_mem_model_i (
    .clk(clk), .plane_addr(paddr), .plane_rd(prd), .plane_we(pwe_o),
    .plane_wdata(pwdata), .plane_rdata(prdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic reg_acc(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk) #1;
    reg_index = idx;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge clk) #1;
    reg_wr = 0;
    reg_rd = 0;
    if (wr) begin
      if (idx == 8'h06) misc_m = d[3:0];
      if (idx == 8'h07) ign_m = d[3:0];
      if (idx == 8'h08) mask_m = d;
    end else
      check(reg_rdata, idx == 8'h06 ? {4'h0, misc_m} : idx == 8'h07 ? {4'h0, ign_m} :
            idx == 8'h08 ? mask_m : 8'h00);
  endtask : reg_acc
  task automatic mem_op(input logic we, input logic [19:0] a);
    logic        hit;
    logic [15:0] off;
    logic [3:0]  pl;
    logic [1:0]  sel;
    logic [7:0]  r;
    logic [31:0] cur;
    logic [31:0] wd;
    int          n;
    case (misc_m[3:2])
      2'b00: hit = a >= 20'hA_0000 && a <= 20'hB_FFFF;
      2'b01: hit = a >= 20'hA_0000 && a <= 20'hA_FFFF;
      2'b10: hit = a >= 20'hB_0000 && a <= 20'hB_7FFF;
      default: hit = a >= 20'hB_8000 && a <= 20'hB_FFFF;
    endcase
    hit = hit && pci_en && moc[1];
    off = misc_m[1] ? {1'b0, a[15:1]} : a[15:0];
    pl = misc_m[1] ? (a[0] ? 4'b1010 : 4'b0101) : 4'hF;
    @(posedge clk) #1;
    mem_req = 1;
    mem_we = we;
    mem_addr = a;
    #1 check(claim, hit);
    @(posedge clk) #1;
    mem_req = 0;
    if (!hit) return;
    check(paddr, off);
    check(prd, !we);
    n = 1;
    while (ack !== 1'b1 && n < 8) begin
      @(posedge clk) #1;
      n++;
    end
    if (n == 8) begin
      errors++;
      summarize();
    end
    check(n, we ? 1 : 3);
    cur = mem_m.exists(off) ? mem_m[off] : 32'h0000_0000;
    if (we) begin
      check(pwe_o, pwe & pl);
      for (int p = 0; p < 4; p++) begin
        wd[8*p+:8] = (wpath[8*p+:8] & mask_m) | (latch_m[8*p+:8] & ~mask_m);
        if (pwe[p] && pl[p])
          cur[8*p+:8] = wd[8*p+:8];
      end
      check(pwdata, wd);
      mem_m[off] = cur;
    end else begin
      latch_m = cur;
      sel = misc_m[1] ? {rsel[1], a[0]} : rsel;
      r = cur[8*sel+:8];
      if (rm1) begin
        r = 8'hFF;
        for (int p = 0; p < 4; p++)
          if (ign_m[p]) r &= ~(cur[8*p+:8] ^ {8{colour[p]}});
      end
      check(mem_rdata, r);
    end
  endtask : mem_op
  initial begin
    seed = $urandom(32'hda8d_193e);
    repeat (2) @(posedge clk);
    #1 rst = 0;
    for (int i = 5; i < 10; i++)
      reg_acc(0, 8'(i), 8'h00);
    reg_acc(1, 8'h06, 8'hFF);
    reg_acc(1, 8'h07, 8'hFF);
    reg_acc(1, 8'h08, 8'h5A);
    for (int i = 6; i < 9; i++)
      reg_acc(0, 8'(i), 8'h00);
    $display("test registers done");
    // Read-modify-write with the low window selected first
    reg_acc(1, 8'h06, 8'h05);
    wpath = $urandom;
    mem_op(1, 20'hA_0010);
    mem_op(0, 20'hA_0010);
    reg_acc(1, 8'h08, 8'h0F);
    wpath = $urandom;
    mem_op(1, 20'hA_0010);
    for (int p = 0; p < 4; p++) begin
      rsel = 2'(p);
      mem_op(0, 20'hA_0010);
    end
    $display("test read-modify-write done");
    for (int i = 0; i < 400; i++) begin
      pci_en = ($urandom_range(7) != 0);
      moc = 8'($urandom);
      if ($urandom_range(3) != 0) moc[1] = 1'b1;
      rm1 = 1'($urandom);
      colour = 4'($urandom);
      rsel = 2'($urandom);
      pwe = 4'($urandom);
      wpath = $urandom;
      case ($urandom_range(5))
        0: reg_acc(1, 8'(6 + $urandom_range(2)), 8'($urandom));
        1: reg_acc(0, 8'(5 + $urandom_range(4)), 8'h00);
        default: mem_op(1'($urandom), bases[$urandom_range(7)] + 20'($urandom_range(15)));
      endcase
      check({chn, gfx}, misc_m[1:0]);
    end
    $display("test random traffic done");
    // Mid-run reset: registers and latches go back to zero, plane memory keeps data
    @(posedge clk) #1;
    rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    misc_m = 4'h0;
    ign_m = 4'h0;
    mask_m = 8'h00;
    latch_m = 32'h0000_0000;
    check({ack, prd, pwe_o, chn, gfx}, 8'h00);
    for (int i = 6; i < 9; i++)
      reg_acc(0, 8'(i), 8'h00);
    pci_en = 1;
    moc = 8'h02;
    pwe = 4'hF;
    mem_op(1, 20'hB_0020);
    mem_op(0, 20'hB_0020);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : vga_gfx_map_compare_mask_tb_top
`default_nettype wire
